// ---- alert_event_irq.sv ----
`timescale 1ns/1ps
`include "alert_regs_consts.svh"
// Sticky event status, enable mask and level interrupt
module alert_event_irq
  import alert_regs_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire alert_regs_pkg::evt_vec_t evt_i,
  input  wire logic                    en_wr_i,
  input  wire logic                    clr_wr_i,
  input  wire alert_regs_pkg::evt_vec_t wdata_i,
  output alert_regs_pkg::evt_vec_t      status_o,
  output alert_regs_pkg::evt_vec_t      enable_o,
  output logic                         irq_o
);
  // Whole state of the interrupt unit
  typedef struct packed {
    evt_vec_t status;  // Sticky events
    evt_vec_t enable;  // Interrupt mask
    logic     irq;     // Registered interrupt level
  } irq_state_t;

  irq_state_t state_reg;
  irq_state_t state_next;

  // New events win over a clear in the same cycle
  always_comb begin
    state_next = state_reg;
    if (en_wr_i) begin
      state_next.enable = wdata_i;
    end
    if (clr_wr_i) begin
      state_next.status = state_reg.status & ~wdata_i;
    end
    state_next.status = state_next.status | evt_i;
    state_next.irq    = (state_next.status & state_next.enable) != '0;
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status_o = state_reg.status;
  assign enable_o = state_reg.enable;
  assign irq_o    = state_reg.irq;
endmodule

// ---- alert_flag_bank.sv ----
`timescale 1ns/1ps
`include "alert_regs_consts.svh"
// Bank of comparator alert flags, refreshed on each acquisition
module alert_flag_bank #(
  parameter int W = `CELL_COUNT
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         acq_i,
  input  wire logic [W-1:0] cmp_i,
  input  wire logic [W-1:0] en_i,
  output logic      [W-1:0] flags_o,
  output logic              rise_o
);
  // Whole state of the bank
  typedef struct packed {
    logic [W-1:0] flags;  // Alert flags
    logic         rise;   // New flag seen pulse
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  // Flag update: sample on acquisition, disabled channels forced low
  always_comb begin
    state_next = state_reg;
    if (acq_i) begin
      state_next.flags = cmp_i & en_i;
    end else begin
      state_next.flags = state_reg.flags & en_i;
    end
    state_next.rise = acq_i && ((cmp_i & en_i & ~state_reg.flags) != '0);
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags_o = state_reg.flags;
  assign rise_o  = state_reg.rise;
endmodule

// ---- alert_regs_consts.svh ----
`ifndef ALERT_REGS_CONSTS_SVH
`define ALERT_REGS_CONSTS_SVH
// Channel counts, register width and address width
`define CELL_COUNT     14
`define AUX_COUNT      6
`define REG_W          16
`define ADDR_W         8
// Alert register offsets
`define OFF_CELL_HIGH  8'h0e
`define OFF_CELL_LOW   8'h0f
`define OFF_AUX_HIGH   8'h10
// Enable and interrupt register offsets
`define OFF_CELL_HI_EN 8'h20
`define OFF_CELL_LO_EN 8'h21
`define OFF_AUX_HI_EN  8'h22
`define OFF_IRQ_STATUS 8'h23
`define OFF_IRQ_ENABLE 8'h24
`define OFF_IRQ_CLEAR  8'h25
// Interrupt event bits
`define EVT_COUNT      3
`define EVT_CELL_HIGH  0
`define EVT_CELL_LOW   1
`define EVT_AUX_HIGH   2
// Reset values
`define CELL_FLAGS_RST 14'h0000
`define AUX_FLAGS_RST  6'h00
`define CELL_EN_RST    14'h0000
`define AUX_EN_RST     6'h00
`define EVT_RST        3'h0
`define WORD_RST       16'h0000
`endif

// ---- alert_regs_pkg.sv ----
`include "alert_regs_consts.svh"
package alert_regs_pkg;
  // Per-channel vectors and bus words
  typedef logic [`CELL_COUNT-1:0] cell_vec_t;
  typedef logic [`AUX_COUNT-1:0]  aux_vec_t;
  typedef logic [`REG_W-1:0]      reg_word_t;
  typedef logic [`ADDR_W-1:0]     reg_addr_t;
  typedef logic [`EVT_COUNT-1:0]  evt_vec_t;

  // Compare outcomes of one comparator acquisition
  typedef struct packed {
    cell_vec_t cell_high;
    cell_vec_t cell_low;
    aux_vec_t  aux_high;
  } cmp_result_t;

  // Register port request
  typedef struct packed {
    reg_addr_t addr;
    reg_word_t wdata;
    logic      wr;
    logic      rd;
  } reg_req_t;
endpackage

// ---- comparator_fault_alert_regs.sv ----
`timescale 1ns/1ps
`include "alert_regs_consts.svh"
// What this block does
// - Cell high flag set when enabled cell exceeds
// - Cell high flag held until next acquisition or until its enable is cleared
// - Cell low flag set when enabled cell below
// - Cell low flag held until next acquisition or until its enable is cleared
// - Cell low register: bits 13:0, zero reset
// - Cell high flags bits 13:0, cell1 lowest
// - Cell low register read-only, writes ignored
// - Aux high register six flags, rest zero
// - Aux flag follows enabled comparator high result
// - Cell high register read-only, zero reset
module comparator_fault_alert_regs
  import alert_regs_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       acq_done_i,
  input  wire alert_regs_pkg::cmp_result_t cmp_i,
  input  wire alert_regs_pkg::reg_req_t    req_i,
  output alert_regs_pkg::reg_word_t        rdata_o,
  output logic                            irq_o
);
  // Whole state of the register front end
  typedef struct packed {
    cell_vec_t cell_high_en;  // Per-cell high alert enable
    cell_vec_t cell_low_en;   // Per-cell low alert enable
    aux_vec_t  aux_high_en;   // Per-input aux high alert enable
    reg_word_t rdata;         // Read data, valid one cycle after strobe
  } front_state_t;

  front_state_t state_reg;
  front_state_t state_next;

  cell_vec_t cell_high_compare_flags;  // Cell high alert flags
  cell_vec_t cell_low_compare_flags;   // Cell low alert flags
  aux_vec_t  aux_high_compare_flags;   // Aux high alert flags
  evt_vec_t  evt;                      // Newly raised alert groups
  evt_vec_t  irq_status;               // Sticky interrupt status
  evt_vec_t  irq_enable;               // Interrupt mask
  logic      wr_irq_en;                // Write to interrupt enable
  logic      wr_irq_clr;               // Write to interrupt clear

  // Address match for one register
  function automatic logic hit(input reg_addr_t a, input reg_addr_t off);
    hit = (a == off);
  endfunction

  // Place a narrow field in the low bits of a word
  function automatic reg_word_t widen(input cell_vec_t v);
    widen = {{(`REG_W-`CELL_COUNT){1'b0}}, v};
  endfunction

  // Cell high flags, one per cell, cell 1 at bit 0
  alert_flag_bank #(
    .W (`CELL_COUNT)
  ) u_cell_high (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .acq_i   (acq_done_i),
    .cmp_i   (cmp_i.cell_high),
    .en_i    (state_reg.cell_high_en),
    .flags_o (cell_high_compare_flags),
    .rise_o  (evt[`EVT_CELL_HIGH])
  );

  // Cell low flags, one per cell, cell 1 at bit 0
  alert_flag_bank #(
    .W (`CELL_COUNT)
  ) u_cell_low (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .acq_i   (acq_done_i),
    .cmp_i   (cmp_i.cell_low),
    .en_i    (state_reg.cell_low_en),
    .flags_o (cell_low_compare_flags),
    .rise_o  (evt[`EVT_CELL_LOW])
  );

  // Aux high flags, one per auxiliary input
  alert_flag_bank #(
    .W (`AUX_COUNT)
  ) u_aux_high (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .acq_i   (acq_done_i),
    .cmp_i   (cmp_i.aux_high),
    .en_i    (state_reg.aux_high_en),
    .flags_o (aux_high_compare_flags),
    .rise_o  (evt[`EVT_AUX_HIGH])
  );

  // Interrupt write decodes
  assign wr_irq_en  = req_i.wr && hit(req_i.addr, `OFF_IRQ_ENABLE);
  assign wr_irq_clr = req_i.wr && hit(req_i.addr, `OFF_IRQ_CLEAR);

  // Sticky status, mask and interrupt line
  alert_event_irq u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .evt_i    (evt),
    .en_wr_i  (wr_irq_en),
    .clr_wr_i (wr_irq_clr),
    .wdata_i  (req_i.wdata[`EVT_COUNT-1:0]),
    .status_o (irq_status),
    .enable_o (irq_enable),
    .irq_o    (irq_o)
  );

  // Register writes and read mux
  always_comb begin
    state_next = state_reg;
    // Enable writes steer flag evaluation
    if (req_i.wr) begin
      case (req_i.addr)
        `OFF_CELL_HI_EN: begin
          state_next.cell_high_en = req_i.wdata[`CELL_COUNT-1:0];
        end
        `OFF_CELL_LO_EN: begin
          state_next.cell_low_en = req_i.wdata[`CELL_COUNT-1:0];
        end
        `OFF_AUX_HI_EN: begin
          state_next.aux_high_en = req_i.wdata[`AUX_COUNT-1:0];
        end
        default: begin
          // Alert registers are read-only; writes there do nothing
          state_next.cell_high_en = state_reg.cell_high_en;
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe
    state_next.rdata = `WORD_RST;
    if (req_i.rd) begin
      case (req_i.addr)
        `OFF_CELL_HIGH: begin
          state_next.rdata = widen(cell_high_compare_flags);
        end
        `OFF_CELL_LOW: begin
          state_next.rdata = widen(cell_low_compare_flags);
        end
        `OFF_AUX_HIGH: begin
          state_next.rdata[`AUX_COUNT-1:0] = aux_high_compare_flags;
        end
        `OFF_CELL_HI_EN: begin
          state_next.rdata = widen(state_reg.cell_high_en);
        end
        `OFF_CELL_LO_EN: begin
          state_next.rdata = widen(state_reg.cell_low_en);
        end
        `OFF_AUX_HI_EN: begin
          state_next.rdata[`AUX_COUNT-1:0] = state_reg.aux_high_en;
        end
        `OFF_IRQ_STATUS: begin
          state_next.rdata[`EVT_COUNT-1:0] = irq_status;
        end
        `OFF_IRQ_ENABLE: begin
          state_next.rdata[`EVT_COUNT-1:0] = irq_enable;
        end
        default: begin
          // Unmapped and write-only addresses read zero
          state_next.rdata = `WORD_RST;
        end
      endcase
    end
  end

  // State register with reset values
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg.cell_high_en <= `CELL_EN_RST;
      state_reg.cell_low_en  <= `CELL_EN_RST;
      state_reg.aux_high_en  <= `AUX_EN_RST;
      state_reg.rdata        <= `WORD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;

  // Checks on the alert flags and register port
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Enable write to a given offset this cycle
  logic wr_hi_en;
  logic wr_lo_en;
  logic wr_aux_en;
  assign wr_hi_en  = req_i.wr && hit(req_i.addr, `OFF_CELL_HI_EN);
  assign wr_lo_en  = req_i.wr && hit(req_i.addr, `OFF_CELL_LO_EN);
  assign wr_aux_en = req_i.wr && hit(req_i.addr, `OFF_AUX_HI_EN);

  // Acquisition loads enabled compare results
  property p_cell_high_set;
    acq_done_i |=> cell_high_compare_flags == $past(cmp_i.cell_high & state_reg.cell_high_en);
  endproperty
  a_cell_high_set: assert property (p_cell_high_set)
    else $error("cell high flags wrong after acquisition");

  // Between acquisitions cell high flags hold; an enable write lands one cycle late
  property p_cell_high_hold;
    !acq_done_i && !wr_hi_en && !$past(wr_hi_en) |=> $stable(cell_high_compare_flags);
  endproperty
  a_cell_high_hold: assert property (p_cell_high_hold)
    else $error("cell high flags changed without acquisition");

  // Acquisition loads enabled low results
  property p_cell_low_set;
    acq_done_i |=> cell_low_compare_flags == $past(cmp_i.cell_low & state_reg.cell_low_en);
  endproperty
  a_cell_low_set: assert property (p_cell_low_set)
    else $error("cell low flags wrong after acquisition");

  // Between acquisitions cell low flags hold; an enable write lands one cycle late
  property p_cell_low_hold;
    !acq_done_i && !wr_lo_en && !$past(wr_lo_en) |=> $stable(cell_low_compare_flags);
  endproperty
  a_cell_low_hold: assert property (p_cell_low_hold)
    else $error("cell low flags changed without acquisition");

  // Cell low register read layout
  property p_cell_low_read;
    req_i.rd && hit(req_i.addr, `OFF_CELL_LOW)
      |=> rdata_o == widen($past(cell_low_compare_flags));
  endproperty
  a_cell_low_read: assert property (p_cell_low_read)
    else $error("cell low register read wrong");

  // Cell high register read layout
  property p_cell_high_read;
    req_i.rd && hit(req_i.addr, `OFF_CELL_HIGH)
      |=> rdata_o == widen($past(cell_high_compare_flags));
  endproperty
  a_cell_high_read: assert property (p_cell_high_read)
    else $error("cell high register read wrong");

  // Write to cell low register has no effect
  property p_cell_low_ro;
    req_i.wr && hit(req_i.addr, `OFF_CELL_LOW) && !acq_done_i && !$past(wr_lo_en)
      |=> $stable(cell_low_compare_flags)
          && $stable({state_reg.cell_high_en, state_reg.cell_low_en, state_reg.aux_high_en});
  endproperty
  a_cell_low_ro: assert property (p_cell_low_ro)
    else $error("write changed read-only cell low register");

  // Aux register read: six flags, upper bits zero
  property p_aux_read;
    req_i.rd && hit(req_i.addr, `OFF_AUX_HIGH)
      |=> rdata_o[`REG_W-1:`AUX_COUNT] == '0
          && rdata_o[`AUX_COUNT-1:0] == $past(aux_high_compare_flags);
  endproperty
  a_aux_read: assert property (p_aux_read)
    else $error("aux register read wrong");

  // Aux flags follow enabled compare results
  property p_aux_set;
    acq_done_i |=> aux_high_compare_flags == $past(cmp_i.aux_high & state_reg.aux_high_en)
      ##1 ($past(acq_done_i) || $past(wr_aux_en, 2) || $stable(aux_high_compare_flags));
  endproperty
  a_aux_set: assert property (p_aux_set)
    else $error("aux flags wrong after acquisition");

  // Write to cell high register has no effect
  property p_cell_high_ro;
    req_i.wr && hit(req_i.addr, `OFF_CELL_HIGH) && !acq_done_i && !$past(wr_hi_en)
      |=> $stable(cell_high_compare_flags);
  endproperty
  a_cell_high_ro: assert property (p_cell_high_ro)
    else $error("write changed read-only cell high register");

  // Disabled channels show no flag from the cycle after the enable drops
  property p_disabled_zero;
    (cell_high_compare_flags & ~$past(state_reg.cell_high_en)) == '0
      && (cell_low_compare_flags & ~$past(state_reg.cell_low_en)) == '0
      && (aux_high_compare_flags & ~$past(state_reg.aux_high_en)) == '0;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("flag set on disabled channel");

  // Main scenarios reached
  property p_cov_high_alert;
    acq_done_i && (cmp_i.cell_high & state_reg.cell_high_en) != '0;
  endproperty
  c_cov_high_alert: cover property (p_cov_high_alert);

  property p_cov_low_clear;
    (cell_low_compare_flags != '0) ##1 (cell_low_compare_flags == '0);
  endproperty
  c_cov_low_clear: cover property (p_cov_low_clear);

  property p_cov_irq;
    $rose(irq_o);
  endproperty
  c_cov_irq: cover property (p_cov_irq);
endmodule

// ---- tb_comparator_fault_alert_regs.sv ----
`timescale 1ns/1ps
`include "alert_regs_consts.svh"
// Self-checking bench for the comparator alert register bank
module tb_comparator_fault_alert_regs;
  import alert_regs_pkg::*;

  logic        clk_i;      // 50 MHz clock
  logic        rst_i;      // Async reset, active high
  logic        acq_done_i; // Acquisition complete pulse
  cmp_result_t cmp_i;      // Compare outcomes
  reg_req_t    req_i;      // Register port request
  reg_word_t   rdata_o;    // Read data
  logic        irq_o;      // Interrupt level
  int          failures;   // Mismatch count
  int          n_compared; // Comparison count

  // Device under test
  comparator_fault_alert_regs u_dut (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .acq_done_i (acq_done_i),
    .cmp_i      (cmp_i),
    .req_i      (req_i),
    .rdata_o    (rdata_o),
    .irq_o      (irq_o)
  );

  // Clock generator
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input reg_word_t seen, input reg_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(posedge clk_i);
    req_i.addr  <= a;
    req_i.wdata <= d;
    req_i.wr    <= 1'b1;
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rdchk(input reg_addr_t a, input reg_word_t exp);
    @(posedge clk_i);
    req_i.addr <= a;
    req_i.rd   <= 1'b1;
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  // One acquisition with given outcomes
  task automatic acq(input cell_vec_t hi, input cell_vec_t lo, input aux_vec_t ax);
    @(posedge clk_i);
    acq_done_i     <= 1'b1;
    cmp_i.cell_high <= hi;
    cmp_i.cell_low  <= lo;
    cmp_i.aux_high  <= ax;
    @(posedge clk_i);
    acq_done_i <= 1'b0;
  endtask

  // Read all three alert registers
  task automatic flags3(input reg_word_t h, input reg_word_t l, input reg_word_t x);
    rdchk(`OFF_CELL_HIGH, h);
    rdchk(`OFF_CELL_LOW, l);
    rdchk(`OFF_AUX_HIGH, x);
  endtask

  // Enable every channel
  task automatic en_all();
    wr(`OFF_CELL_HI_EN, 16'h3fff);
    wr(`OFF_CELL_LO_EN, 16'h3fff);
    wr(`OFF_AUX_HI_EN, 16'h003f);
  endtask

  // Reset values and an unmapped read
  task automatic t_reset();
    rdchk(`OFF_CELL_HIGH, 16'h0000);
    rdchk(`OFF_CELL_LOW, 16'h0000);
    rdchk(`OFF_AUX_HIGH, 16'h0000);
    rdchk(8'h30, 16'h0000);
    chk({15'h0000, irq_o}, 16'h0000);
  endtask

  // Walking one through each channel checks bit placement
  task automatic t_order();
    en_all();
    for (int i = 0; i < `CELL_COUNT; i++) begin
      acq(14'(1 << i), 14'(1 << (13 - i)), 6'(1 << (i % 6)));
      rdchk(`OFF_CELL_HIGH, 16'(1 << i));
      rdchk(`OFF_CELL_LOW, 16'(1 << (13 - i)));
      rdchk(`OFF_AUX_HIGH, 16'(1 << (i % 6)));
    end
    acq(14'h3fff, 14'h3fff, 6'h3f);
    flags3(16'h3fff, 16'h3fff, 16'h003f);
  endtask

  // Disabled channels stay at zero
  task automatic t_enable();
    wr(`OFF_CELL_HI_EN, 16'h1555);
    wr(`OFF_CELL_LO_EN, 16'h2aaa);
    wr(`OFF_AUX_HI_EN, 16'h0015);
    acq(14'h3fff, 14'h3fff, 6'h3f);
    flags3(16'h1555, 16'h2aaa, 16'h0015);
    wr(`OFF_CELL_HI_EN, 16'h0000);
    rdchk(`OFF_CELL_HIGH, 16'h0000);
  endtask

  // Flags hold between acquisitions and clear only when resolved
  task automatic t_hold();
    en_all();
    acq(14'h3fff, 14'h3fff, 6'h3f);
    @(posedge clk_i);
    cmp_i <= '0;
    repeat (4) @(posedge clk_i);
    flags3(16'h3fff, 16'h3fff, 16'h003f);
    acq(14'h0000, 14'h2001, 6'h01);
    flags3(16'h0000, 16'h2001, 16'h0001);
  endtask

  // Writes to the alert registers leave them unchanged
  task automatic t_ro();
    wr(`OFF_CELL_HIGH, 16'hffff);
    wr(`OFF_CELL_LOW, 16'h0000);
    wr(`OFF_AUX_HIGH, 16'hffff);
    flags3(16'h0000, 16'h2001, 16'h0001);
  endtask

  // Rising flag raises status and interrupt, then mask and clear
  task automatic t_irq();
    int n;
    acq(14'h0000, 14'h0000, 6'h00);
    wr(`OFF_IRQ_CLEAR, 16'h0007);
    wr(`OFF_IRQ_ENABLE, 16'h0001);
    acq(14'h0001, 14'h0000, 6'h00);
    n = 0;
    while (irq_o !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // Interrupt never came: count it and stop here
    if (n == 8) begin
      failures++;
      conclude();
    end
    chk({15'h0000, irq_o}, 16'h0001);
    rdchk(`OFF_IRQ_STATUS, 16'h0001);
    wr(`OFF_IRQ_ENABLE, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1;
    chk({15'h0000, irq_o}, 16'h0000);
    wr(`OFF_IRQ_CLEAR, 16'h0001);
    rdchk(`OFF_IRQ_STATUS, 16'h0000);
  endtask

  // Main sequence
  initial begin
    failures   = 0;
    n_compared = 0;
    rst_i      = 1'b1;
    acq_done_i = 1'b0;
    cmp_i      = '0;
    req_i      = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_order();
    t_enable();
    t_hold();
    t_ro();
    t_irq();
    conclude();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    conclude();
  end
endmodule
